// ==== hw/eii_pkg.sv ====
// What this block does
// - Any input may be an interrupt source
// - Per input: none, rise, fall, both
// - At most one pending event per input
// - Extra edges on pending input silently dropped
// - Start bytes 6/7 hold module address 7C
// - Bytes 8 on hold triggering input bitmap
// - No diagnostics for standard I/O
// - Analog output range, default plus/minus 10 V
// - Channels 0,1 output type, default voltage
// - AI/AO parameter record is 13 bytes
package eii_pkg;
  localparam int N_IN = 24;
  localparam int N_AO = 2;
  localparam int PARAM_BYTES = 13;
  // Edge selection codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Analog output range codes
  localparam logic [2:0] RNG_OFF = 3'h0;
  localparam logic [2:0] RNG_PM20MA = 3'h1;
  localparam logic [2:0] RNG_0_20MA = 3'h2;
  localparam logic [2:0] RNG_4_20MA = 3'h3;
  localparam logic [2:0] RNG_PM10V = 3'h4;
  localparam logic [2:0] RNG_0_10V = 3'h5;
  localparam logic [2:0] RNG_RESET = RNG_PM10V;
  // Analog output type codes
  localparam logic [1:0] TYP_OFF = 2'h0;
  localparam logic [1:0] TYP_VOLT = 2'h1;
  localparam logic [1:0] TYP_CURR = 2'h2;
  localparam logic [1:0] TYP_RESET = TYP_VOLT;
  // Start information
  localparam logic [15:0] MOD_ADDR = 16'h007C;
  localparam int SI_ADDR_BYTE = 6;
  localparam int SI_MAP_BYTE = 8;
  // Register word offsets
  localparam logic [3:0] A_EDGE_LO = 4'h0;
  localparam logic [3:0] A_EDGE_HI = 4'h1;
  localparam logic [3:0] A_PEND = 4'h2;
  localparam logic [3:0] A_MASK = 4'h3;
  localparam logic [3:0] A_AO_CFG = 4'h4;
  localparam logic [3:0] A_SI_ADDR = 4'h5;
  localparam logic [3:0] A_SI_MAP = 4'h6;
  localparam logic [3:0] A_DIAG = 4'h7;
  // AO config field positions: per channel 3 range bits, 2 type bits
  localparam int AO_FLD_W = 5;
  localparam int AO_RNG_LSB = 0;
  localparam int AO_TYP_LSB = 3;
endpackage

// ==== hw/eii_edge_chan.sv ====
`timescale 1ns/10ps
// Single-input edge detector with one-deep pending latch
module eii_edge_chan (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic [1:0] i_sel,
  input wire logic i_din,
  input wire logic i_clr,
  // Status
  output logic o_pend
);
  import eii_pkg::*;
  logic prev_reg, prev_next, pend_reg, pend_next, hit;

  always_comb begin
    prev_next = i_din;
    hit = 1'b0;
    case (i_sel)
      EDGE_RISE: hit = i_din & ~prev_reg;
      EDGE_FALL: hit = ~i_din & prev_reg;
      EDGE_BOTH: hit = i_din ^ prev_reg;
      default: hit = 1'b0;
    endcase
    // One event held, more dropped; new edge wins over clear
    pend_next = pend_reg;
    if (i_clr) begin
      pend_next = 1'b0;
    end
    if (hit) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prev_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      pend_reg <= pend_next;
    end
  end

  assign o_pend = pend_reg;

  // Held event survives until cleared
  property p_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
    pend_reg && !i_clr |=> pend_reg;
  endproperty
  a_hold: assert property (p_hold)
    else $error("pending event lost");

  // Selected rising edge latches an event
  property p_rise;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_sel == EDGE_RISE && i_din && !prev_reg |=> pend_reg;
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge not latched");
endmodule

// ==== hw/eii_top.sv ====
`timescale 1ns/10ps
// Edge interrupt inputs with analog output parameter store
module eii_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Field inputs
  input wire logic [eii_pkg::N_IN-1:0] i_din,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Handler side
  output logic o_process_interrupt_flag,
  output logic [15:0] o_triggering_module_address,
  output logic [31:0] o_triggering_input_bitmap,
  output logic [eii_pkg::PARAM_BYTES*8-1:0] o_param_record
);
  import eii_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] edge_lo_reg, edge_lo_next, edge_hi_reg, edge_hi_next;
  logic [N_IN-1:0] mask_reg, mask_next, clr, pend;
  logic [N_AO*AO_FLD_W-1:0] ao_reg, ao_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [63:0] sel_all;

  assign sel_all = {edge_hi_reg, edge_lo_reg};

  always_comb begin
    edge_lo_next = edge_lo_reg;
    edge_hi_next = edge_hi_reg;
    mask_next = mask_reg;
    ao_next = ao_reg;
    clr = '0;
    if (i_wr) begin
      case (i_addr)
        A_EDGE_LO: edge_lo_next = i_wdata;
        A_EDGE_HI: edge_hi_next = {16'h0000, i_wdata[15:0]};
        A_MASK: mask_next = i_wdata[N_IN-1:0];
        A_AO_CFG: ao_next = i_wdata[N_AO*AO_FLD_W-1:0];
        A_PEND: clr = i_wdata[N_IN-1:0];
        default: clr = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-input edge channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_ch
      eii_edge_chan u_ch (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_sel(sel_all[2*g+1:2*g]),
        .i_din(i_din[g]),
        .i_clr(clr[g]),
        .o_pend(pend[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux and handler outputs
  // ----------------------------------------------------------------
  logic [31:0] map32;
  logic [PARAM_BYTES*8-1:0] rec;
  assign map32 = {{(32-N_IN){1'b0}}, pend};

  always_comb begin
    rec = '0;
    for (int c = 0; c < N_AO; c++) begin
      rec[8*c +: 8] = {5'h00,
        ao_reg[c*AO_FLD_W+AO_RNG_LSB +: 3]};
      rec[8*(c+2) +: 8] = {6'h00,
        ao_reg[c*AO_FLD_W+AO_TYP_LSB +: 2]};
    end
    rdata_next = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        A_EDGE_LO: rdata_next = edge_lo_reg;
        A_EDGE_HI: rdata_next = edge_hi_reg;
        A_PEND: rdata_next = map32;
        A_MASK: rdata_next = {{(32-N_IN){1'b0}}, mask_reg};
        A_AO_CFG: rdata_next = {22'h000000, ao_reg};
        A_SI_ADDR: rdata_next = {16'h0000, MOD_ADDR};
        A_SI_MAP: rdata_next = map32 & {8'h00, mask_reg};
        A_DIAG: rdata_next = 32'h0000_0000;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      edge_lo_reg <= 32'h0000_0000;
      edge_hi_reg <= 32'h0000_0000;
      mask_reg <= '0;
      ao_reg <= {N_AO{TYP_RESET, RNG_RESET}};
      rdata_reg <= 32'h0000_0000;
    end else begin
      edge_lo_reg <= edge_lo_next;
      edge_hi_reg <= edge_hi_next;
      mask_reg <= mask_next;
      ao_reg <= ao_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_triggering_module_address = MOD_ADDR;
  assign o_triggering_input_bitmap = map32 & {8'h00, mask_reg};
  assign o_process_interrupt_flag = |(pend & mask_reg);
  assign o_param_record = rec;

  property p_irq;
    @(posedge i_clk) disable iff (i_sys_rst)
    |(pend & mask_reg) |-> o_process_interrupt_flag;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq missing");

  property p_addr;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_triggering_module_address == 16'h007C;
  endproperty
  a_addr: assert property (p_addr)
    else $error("bad module address");

  property p_clr;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_wr && i_addr == A_PEND && i_wdata[0]
    && !(i_din[0] ^ $past(i_din[0]))
    && sel_all[1:0] == EDGE_NONE |=> !pend[0];
  endproperty
  a_clr: assert property (p_clr)
    else $error("pending not cleared");

  property p_rd;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_rd && i_addr == A_DIAG |=> o_rdata == 32'h0;
  endproperty
  a_rd: assert property (p_rd)
    else $error("diag nonzero");
endmodule

// ==== verification/eii_field_model.sv ====
`timescale 1ns/10ps
// Field inputs facing the block
module eii_field_model (
  input wire logic i_clk,
  output logic [eii_pkg::N_IN-1:0] o_din
);
  initial o_din = '0;
  // One input changes just after an edge
  task automatic drive(input int ch, input logic lvl);
    @(posedge i_clk);
    o_din[ch] <= lvl;
  endtask
endmodule

// ==== verification/tb_eii_top.sv ====
`timescale 1ns/10ps
module tb_eii_top;
  import eii_pkg::*;
  logic i_clk, i_sys_rst, i_wr, i_rd, flag;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, o_map;
  logic [N_IN-1:0] din;
  logic [15:0] maddr;
  logic [PARAM_BYTES*8-1:0] prec;
  int n_errors = 0;
  int cmp_count = 0;
  eii_field_model eii_field_model_inst (.i_clk(i_clk), .o_din(din));
  eii_top eii_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_din(din), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_process_interrupt_flag(flag),
    .o_triggering_module_address(maddr),
    .o_triggering_input_bitmap(o_map), .o_param_record(prec));
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ------------------------------
  // Bus tasks and compare
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
    #1;
  endtask
  task automatic chkrd(input string nm, input logic [3:0] a,
                       input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    #1;
    chk(nm, e, o_rdata);
  endtask
  task automatic pulse(input int ch, input logic lvl);
    eii_field_model_inst.drive(ch, lvl);
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
  initial begin
    i_sys_rst = 1;
    i_wr = 0;
    i_rd = 0;
    i_addr = '0;
    i_wdata = '0;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 0;
    chkrd("edge_lo", A_EDGE_LO, 32'h0);
    chkrd("ao_cfg", A_AO_CFG, 32'h0000018C);
    chk("record", 32'h01010404, prec[31:0]);
    chk("record_hi", 32'h0, prec[63:32]);
    chkrd("si_addr", A_SI_ADDR, 32'h0000007C);
    chk("mod_addr", 32'h0000007C, {16'h0, maddr});
    chkrd("diag", A_DIAG, 32'h0);
    wr(4'h9, 32'hFFFFFFFF);
    chkrd("unmapped", 4'h9, 32'h0);
    wr(A_AO_CFG, 32'h00000035);
    chkrd("ao_back", A_AO_CFG, 32'h00000035);
    chk("record2", 32'h00020105, prec[31:0]);
    $display("test config done");
    wr(A_MASK, 32'h00FFFFFF);
    for (int c = 0; c < 4; c++) begin
      wr(A_EDGE_LO, 32'(c));
      pulse(0, 1);
      chkrd("pend_rise", A_PEND, {31'h0, c[0]});
      wr(A_PEND, 32'h1);
      pulse(0, 0);
      chkrd("pend_fall", A_PEND, {31'h0, c[1]});
      wr(A_PEND, 32'h1);
    end
    $display("test edge modes done");
    wr(A_EDGE_LO, 32'h3);
    pulse(0, 1);
    pulse(0, 0);
    chk("flag", 32'h1, {31'h0, flag});
    chk("bitmap", 32'h1, o_map);
    chkrd("si_map", A_SI_MAP, 32'h1);
    wr(A_MASK, 32'h0);
    chk("masked", 32'h0, o_map);
    chkrd("pend_kept", A_PEND, 32'h1);
    wr(A_MASK, 32'h00FFFFFF);
    wr(A_PEND, 32'h1);
    chkrd("pend_once", A_PEND, 32'h0);
    chk("flag_clr", 32'h0, {31'h0, flag});
    wr(A_EDGE_HI, 32'hC);
    pulse(17, 1);
    chkrd("pend17", A_PEND, 32'h00020000);
    chk("map17", 32'h00020000, o_map);
    $display("test pending done");
    conclude();
  end
endmodule
